// ### rtl/eds_cfg.svh
// constants of the dma event-flag and operation-control block
// assumes an apb slave with 32-bit data and byte addresses
`ifndef EDS_CFG_SVH
`define EDS_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define EDS_OFF_COMMAND 16'h1000
`define EDS_OFF_POLL 16'h1004
`define EDS_OFF_FLAGS 16'h1014
`define EDS_OFF_OPCTL 16'h1018
`define EDS_OFF_MASK 16'h101c

// ---------------------------------------------------------------
// event flag bit positions
// ---------------------------------------------------------------
`define EDS_BIT_TX_FRAME_DONE 0
`define EDS_BIT_TX_STOPPED 1
`define EDS_BIT_TX_DESC_UNAVAIL 2
`define EDS_BIT_TX_JABBER 3
`define EDS_BIT_RX_OVERFLOW 4
`define EDS_BIT_TX_UNDERFLOW 5
`define EDS_BIT_RX_FRAME_DONE 6
`define EDS_BIT_RX_DESC_UNAVAIL 7
`define EDS_BIT_ABN_SUMMARY 15
`define EDS_ABN_FLAGS 8'hba

// ---------------------------------------------------------------
// operation control fields
// ---------------------------------------------------------------
`define EDS_BIT_KEEP_CSUM 26
`define EDS_BIT_RX_SF 25
`define EDS_BIT_KEEP_RX_NODESC 24
`define EDS_BIT_TX_SF 21
`define EDS_TTC_LSB 14
`define EDS_OPCTL_WMASK 32'h0721_c000
`define EDS_OPCTL_RESET 32'h0000_0000
`define EDS_FLAGS_RESET 8'h00
`define EDS_MASK_RESET 8'h00

// ---------------------------------------------------------------
// command and poll bits, descriptor status bits
// ---------------------------------------------------------------
`define EDS_CMD_TX_START 0
`define EDS_CMD_RX_START 1
`define EDS_CMD_TX_STOP 2
`define EDS_CMD_RX_STOP 3
`define EDS_POLL_TX 0
`define EDS_POLL_RX 1
`define EDS_TXD0_UNDERFLOW 1
`define EDS_TXD0_JABBER 14
`define EDS_RXD0_OVERFLOW 11

`endif

// ### rtl/eds_pkg.sv
// types shared by the dma event-flag block, its assertion monitor and the engine model
// assumes eds_cfg.svh supplies the numeric constants
`default_nettype none

package eds_pkg;

    // -----------------------------------------------------------
    // dma process states
    // -----------------------------------------------------------
    typedef enum logic [1:0] {
        EDS_STOPPED = 2'b00,
        EDS_RUNNING = 2'b01,
        EDS_SUSPENDED = 2'b10
    } eds_proc_t;

    // -----------------------------------------------------------
    // event strobes from the dma engines, one-cycle pulses
    // -----------------------------------------------------------
    typedef struct packed {
        logic rx_desc_fetch;
        logic rx_desc_dma_owned;
        logic rx_frame_recognized;
        logic rx_frame_done;
        logic rx_overflow;
        logic rx_partial_passed;
        logic tx_desc_fetch;
        logic tx_desc_dma_owned;
        logic tx_underflow;
        logic tx_jabber;
        logic tx_frame_done;
        logic tx_ioc;
    } eds_evt_t;

    // descriptor first-word write-back
    typedef struct packed {
        logic valid;
        logic [31:0] word0;
    } eds_desc_wr_t;

endpackage : eds_pkg

`default_nettype wire

// ### rtl/eds_tx_start.sv
// transmit start decision from fifo fill and operation control
// assumes fifo level and whole-frame flag come from pclk logic
`timescale 1ns/10ps
`default_nettype none
`include "eds_cfg.svh"

module eds_tx_start (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_store_forward,
    input wire logic [2:0] tx_threshold,
    input wire logic [8:0] tx_fifo_bytes,
    input wire logic tx_fifo_whole_frame,
    output logic tx_start_ok,
    output logic [8:0] tx_start_level
);

    // -----------------------------------------------------------
    // threshold decode
    // -----------------------------------------------------------
    function automatic logic [8:0] level_of(input logic [2:0] code);
        case (code)
            3'h0: level_of = 9'h040;
            3'h1: level_of = 9'h080;
            3'h2: level_of = 9'h0c0;
            3'h3: level_of = 9'h100;
            3'h4: level_of = 9'h028;
            3'h5: level_of = 9'h020;
            3'h6: level_of = 9'h018;
            default: level_of = 9'h010;
        endcase
    endfunction : level_of

    wire logic [8:0] level_w;
    wire logic over_w;
    wire logic start_next;

    assign level_w = level_of(tx_threshold);
    assign over_w = tx_fifo_bytes > level_w;
    // store-and-forward ignores the threshold
    assign start_next = tx_store_forward ? tx_fifo_whole_frame
                                         : (tx_fifo_whole_frame | over_w);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_start_ok <= 1'b0;
            tx_start_level <= 9'h000;
        end
        else
        begin
            tx_start_ok <= start_next;
            tx_start_level <= level_w;
        end
    end

endmodule : eds_tx_start

`default_nettype wire

// ### rtl/eds_dma_status.sv
// dma event flags, operation control and process states, apb slave
// assumes event strobes are one-cycle pulses on pclk from the dma engines
`timescale 1ns/10ps
`default_nettype none
`include "eds_cfg.svh"

module eds_dma_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire eds_pkg::eds_evt_t evt,
    input wire logic [31:0] rx_frame_status,
    input wire logic forward_error_frames,
    input wire logic [8:0] tx_fifo_bytes,
    input wire logic tx_fifo_whole_frame,
    output eds_pkg::eds_desc_wr_t rx_desc_wr,
    output eds_pkg::eds_desc_wr_t tx_desc_wr,
    output eds_pkg::eds_proc_t rx_state,
    output eds_pkg::eds_proc_t tx_state,
    output logic rx_store_forward,
    output logic rx_flush_on_no_desc,
    output logic rx_drop_csum_errors,
    output logic tx_start_ok,
    output logic [8:0] tx_start_level,
    output logic irq
);

    // -----------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------
    logic pready_reg;
    wire logic setup_w;
    wire logic access_w;
    wire logic wr_w;
    wire logic hit_cmd;
    wire logic hit_poll;
    wire logic hit_flags;
    wire logic hit_opctl;
    wire logic hit_mask;
    wire logic hit_any;

    // word match, byte lanes ignored
    function automatic logic hit_of(input logic [15:0] a,
                                    input logic [15:0] off);
        hit_of = a[15:2] == off[15:2];
    endfunction : hit_of

    // no wait state: setup cycle loads the answer, first access cycle sees pready
    assign setup_w = psel & ~penable;
    assign access_w = psel & penable & pready_reg;
    assign wr_w = access_w & pwrite;
    assign hit_cmd = hit_of(paddr, `EDS_OFF_COMMAND);
    assign hit_poll = hit_of(paddr, `EDS_OFF_POLL);
    assign hit_flags = hit_of(paddr, `EDS_OFF_FLAGS);
    assign hit_opctl = hit_of(paddr, `EDS_OFF_OPCTL);
    assign hit_mask = hit_of(paddr, `EDS_OFF_MASK);
    assign hit_any = hit_cmd | hit_poll | hit_flags | hit_opctl | hit_mask;

    // -----------------------------------------------------------
    // software strobes
    // -----------------------------------------------------------
    wire logic tx_start_cmd;
    wire logic rx_start_cmd;
    wire logic tx_stop_cmd;
    wire logic rx_stop_cmd;
    wire logic tx_poll;
    wire logic rx_poll;
    wire logic [7:0] flag_clr;

    assign tx_start_cmd = wr_w & hit_cmd & pwdata[`EDS_CMD_TX_START];
    assign rx_start_cmd = wr_w & hit_cmd & pwdata[`EDS_CMD_RX_START];
    assign tx_stop_cmd = wr_w & hit_cmd & pwdata[`EDS_CMD_TX_STOP];
    assign rx_stop_cmd = wr_w & hit_cmd & pwdata[`EDS_CMD_RX_STOP];
    assign tx_poll = wr_w & hit_poll & pwdata[`EDS_POLL_TX];
    assign rx_poll = wr_w & hit_poll & pwdata[`EDS_POLL_RX];
    assign flag_clr = (wr_w & hit_flags) ? pwdata[7:0] : 8'h00;

    // -----------------------------------------------------------
    // receive process
    // -----------------------------------------------------------
    eds_pkg::eds_proc_t rx_state_reg;
    eds_pkg::eds_proc_t rx_state_next;
    logic rx_prev_dma_reg;
    logic rx_ovf_pend_reg;
    wire logic rx_run;
    wire logic rx_no_desc;
    wire logic rx_ru_set;
    wire logic rx_resume;

    assign rx_run = rx_state_reg == eds_pkg::EDS_RUNNING;
    assign rx_no_desc = rx_run & evt.rx_desc_fetch & ~evt.rx_desc_dma_owned;
    assign rx_ru_set = rx_no_desc & rx_prev_dma_reg;
    assign rx_resume = rx_poll | evt.rx_frame_recognized;

    always_comb
    begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            eds_pkg::EDS_STOPPED:
                if (rx_start_cmd)
                    rx_state_next = eds_pkg::EDS_RUNNING;
            eds_pkg::EDS_RUNNING:
                if (rx_stop_cmd)
                    rx_state_next = eds_pkg::EDS_STOPPED;
                else if (rx_no_desc)
                    rx_state_next = eds_pkg::EDS_SUSPENDED;
            eds_pkg::EDS_SUSPENDED:
                if (rx_stop_cmd)
                    rx_state_next = eds_pkg::EDS_STOPPED;
                else if (rx_resume)
                    rx_state_next = eds_pkg::EDS_RUNNING;
            default:
                rx_state_next = eds_pkg::EDS_STOPPED;
        endcase
    end

    // -----------------------------------------------------------
    // transmit process
    // -----------------------------------------------------------
    eds_pkg::eds_proc_t tx_state_reg;
    eds_pkg::eds_proc_t tx_state_next;
    wire logic tx_run;
    wire logic tx_no_desc;
    wire logic tx_unf;
    wire logic tx_jab;
    wire logic tx_enter_stop;

    assign tx_run = tx_state_reg == eds_pkg::EDS_RUNNING;
    assign tx_no_desc = tx_run & evt.tx_desc_fetch & ~evt.tx_desc_dma_owned;
    assign tx_unf = tx_run & evt.tx_underflow;
    assign tx_jab = (tx_state_reg != eds_pkg::EDS_STOPPED) & evt.tx_jabber;
    assign tx_enter_stop = (tx_state_next == eds_pkg::EDS_STOPPED) &
                           (tx_state_reg != eds_pkg::EDS_STOPPED);

    always_comb
    begin
        tx_state_next = tx_state_reg;
        case (tx_state_reg)
            eds_pkg::EDS_STOPPED:
                if (tx_start_cmd)
                    tx_state_next = eds_pkg::EDS_RUNNING;
            eds_pkg::EDS_RUNNING:
                if (tx_stop_cmd | tx_jab)
                    tx_state_next = eds_pkg::EDS_STOPPED;
                else if (tx_unf)
                    tx_state_next = eds_pkg::EDS_SUSPENDED;
                else if (tx_no_desc)
                    tx_state_next = eds_pkg::EDS_SUSPENDED;
            eds_pkg::EDS_SUSPENDED:
                if (tx_stop_cmd | tx_jab)
                    tx_state_next = eds_pkg::EDS_STOPPED;
                else if (tx_poll)
                    tx_state_next = eds_pkg::EDS_RUNNING;
            default:
                tx_state_next = eds_pkg::EDS_STOPPED;
        endcase
    end

    // -----------------------------------------------------------
    // event flags and mask
    // -----------------------------------------------------------
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] mask_reg;
    wire logic [7:0] flag_set;
    wire logic abn_summary;

    assign flag_set[`EDS_BIT_TX_FRAME_DONE] =
        evt.tx_frame_done & evt.tx_ioc;
    assign flag_set[`EDS_BIT_TX_STOPPED] = tx_enter_stop;
    assign flag_set[`EDS_BIT_TX_DESC_UNAVAIL] =
        tx_no_desc & ~tx_unf & ~tx_jab & ~tx_stop_cmd;
    assign flag_set[`EDS_BIT_TX_JABBER] = tx_jab;
    assign flag_set[`EDS_BIT_RX_OVERFLOW] = evt.rx_overflow;
    assign flag_set[`EDS_BIT_TX_UNDERFLOW] = tx_unf & ~tx_jab;
    assign flag_set[`EDS_BIT_RX_FRAME_DONE] = evt.rx_frame_done;
    assign flag_set[`EDS_BIT_RX_DESC_UNAVAIL] = rx_ru_set;

    // a set in the clearing cycle wins
    assign flags_next = (flags_reg & ~flag_clr) | flag_set;
    assign abn_summary = |(flags_reg & mask_reg & `EDS_ABN_FLAGS);

    // -----------------------------------------------------------
    // operation control
    // -----------------------------------------------------------
    logic [31:0] opctl_reg;
    wire logic keep_csum_error_frames;
    wire logic keep_rx_on_no_desc;
    wire logic rx_sf_w;
    wire logic tx_store_forward;
    wire logic [2:0] tx_threshold;

    assign keep_csum_error_frames = opctl_reg[`EDS_BIT_KEEP_CSUM];
    assign rx_sf_w = opctl_reg[`EDS_BIT_RX_SF];
    assign keep_rx_on_no_desc = opctl_reg[`EDS_BIT_KEEP_RX_NODESC];
    assign tx_store_forward = opctl_reg[`EDS_BIT_TX_SF];
    assign tx_threshold = opctl_reg[`EDS_TTC_LSB +: 3];

    // -----------------------------------------------------------
    // read data
    // -----------------------------------------------------------
    wire logic [31:0] rd_cmd;
    wire logic [31:0] rd_flags;
    wire logic [31:0] rd_mux;

    assign rd_cmd = {26'h0000000, rx_state_reg, 2'h0, tx_state_reg};
    assign rd_flags = {16'h0000, abn_summary, 7'h00, flags_reg};
    assign rd_mux = hit_cmd ? rd_cmd :
                    hit_flags ? rd_flags :
                    hit_opctl ? opctl_reg :
                    hit_mask ? {24'h000000, mask_reg} : 32'h0000_0000;

    // -----------------------------------------------------------
    // descriptor write-back
    // -----------------------------------------------------------
    eds_pkg::eds_desc_wr_t rx_desc_next;
    eds_pkg::eds_desc_wr_t tx_desc_next;
    wire logic rx_ovf_now;
    wire logic [31:0] rx_ovf_bit;
    wire logic [31:0] tx_unf_bit;
    wire logic [31:0] tx_jab_bit;

    assign rx_ovf_now = rx_ovf_pend_reg |
                        (evt.rx_overflow & evt.rx_partial_passed);
    assign rx_ovf_bit = 32'h0000_0001 << `EDS_RXD0_OVERFLOW;
    assign tx_unf_bit = 32'h0000_0001 << `EDS_TXD0_UNDERFLOW;
    assign tx_jab_bit = 32'h0000_0001 << `EDS_TXD0_JABBER;

    always_comb
    begin
        rx_desc_next.valid = evt.rx_frame_done;
        rx_desc_next.word0 = rx_frame_status |
                             (rx_ovf_now ? rx_ovf_bit : 32'h0000_0000);
        tx_desc_next.valid = evt.tx_frame_done | tx_unf | tx_jab;
        tx_desc_next.word0 = (tx_unf ? tx_unf_bit : 32'h0000_0000) |
                             (tx_jab ? tx_jab_bit : 32'h0000_0000);
    end

    // -----------------------------------------------------------
    // state registers
    // -----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state_reg <= eds_pkg::EDS_STOPPED;
            tx_state_reg <= eds_pkg::EDS_STOPPED;
            rx_prev_dma_reg <= 1'b1;
            rx_ovf_pend_reg <= 1'b0;
            flags_reg <= `EDS_FLAGS_RESET;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            tx_state_reg <= tx_state_next;
            if (evt.rx_desc_fetch)
                rx_prev_dma_reg <= evt.rx_desc_dma_owned;
            // partial frame overflow is carried to that frame's write-back
            if (evt.rx_frame_done)
                rx_ovf_pend_reg <= 1'b0;
            else if (evt.rx_overflow & evt.rx_partial_passed)
                rx_ovf_pend_reg <= 1'b1;
            flags_reg <= flags_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opctl_reg <= `EDS_OPCTL_RESET;
            mask_reg <= `EDS_MASK_RESET;
        end
        else
        begin
            // reserved bits never store
            if (wr_w & hit_opctl)
                opctl_reg <= pwdata & `EDS_OPCTL_WMASK;
            if (wr_w & hit_mask)
                mask_reg <= pwdata[7:0];
        end
    end

    // -----------------------------------------------------------
    // outputs
    // -----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            rx_desc_wr <= '0;
            tx_desc_wr <= '0;
            rx_store_forward <= 1'b0;
            rx_flush_on_no_desc <= 1'b1;
            rx_drop_csum_errors <= 1'b1;
            irq <= 1'b0;
        end
        else
        begin
            pready_reg <= setup_w;
            if (setup_w)
            begin
                prdata <= rd_mux;
                pslverr <= ~hit_any;
            end
            rx_desc_wr <= rx_desc_next;
            tx_desc_wr <= tx_desc_next;
            rx_store_forward <= rx_sf_w;
            rx_flush_on_no_desc <= ~keep_rx_on_no_desc;
            rx_drop_csum_errors <= ~keep_csum_error_frames &
                                   ~forward_error_frames;
            irq <= |(flags_reg & mask_reg);
        end
    end

    assign pready = pready_reg;
    assign rx_state = rx_state_reg;
    assign tx_state = tx_state_reg;

    // -----------------------------------------------------------
    // transmit start level
    // -----------------------------------------------------------
    eds_tx_start u_tx_start (
        .pclk(pclk),
        .presetn(presetn),
        .tx_store_forward(tx_store_forward),
        .tx_threshold(tx_threshold),
        .tx_fifo_bytes(tx_fifo_bytes),
        .tx_fifo_whole_frame(tx_fifo_whole_frame),
        .tx_start_ok(tx_start_ok),
        .tx_start_level(tx_start_level)
    );

endmodule : eds_dma_status

`default_nettype wire

// ### dv/eds_dma_status_monitor.sv
// assertions on the ports of the dma event-flag block
// assumes eds_pkg is compiled before this file
`timescale 1ns/10ps
`default_nettype none

module eds_dma_status_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire eds_pkg::eds_evt_t evt,
    input wire logic [31:0] rx_frame_status,
    input wire eds_pkg::eds_desc_wr_t rx_desc_wr,
    input wire eds_pkg::eds_desc_wr_t tx_desc_wr,
    input wire eds_pkg::eds_proc_t rx_state,
    input wire eds_pkg::eds_proc_t tx_state,
    input wire logic rx_store_forward,
    input wire logic rx_flush_on_no_desc
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic wr_acc = psel && penable && pready && pwrite;
    // a command write in the same cycle may outrank an event
    wire logic cmd_wr = psel && penable && pwrite && paddr == 16'h1000;
    a_pready_setup: assert property (
        psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_jabber_stop: assert property (
        evt.tx_jabber && tx_state != 2'h0 |=> tx_state == 2'h0 &&
        tx_desc_wr.valid && tx_desc_wr.word0[14])
        else $error("jabber did not stop tx");
    a_underflow_susp: assert property (
        evt.tx_underflow && !evt.tx_jabber && !cmd_wr && tx_state == 2'h1
        |=> tx_state == 2'h2 && tx_desc_wr.valid && tx_desc_wr.word0[1])
        else $error("underflow did not suspend tx");
    a_txdesc_susp: assert property (
        evt.tx_desc_fetch && !evt.tx_desc_dma_owned && tx_state == 2'h1 &&
        !evt.tx_underflow && !evt.tx_jabber && !cmd_wr |=> tx_state == 2'h2)
        else $error("host-owned tx descriptor did not suspend");
    a_rx_writeback: assert property (
        evt.rx_frame_done |=> rx_desc_wr.valid &&
        (rx_desc_wr.word0 | 32'h800) == ($past(rx_frame_status) | 32'h800))
        else $error("rx status not written back");
    a_rx_keeps_run: assert property (
        evt.rx_frame_done && rx_state == 2'h1 && !evt.rx_desc_fetch &&
        !cmd_wr |=> rx_state == 2'h1)
        else $error("rx left running on frame done");
    a_rx_resume: assert property (
        evt.rx_frame_recognized && rx_state == 2'h2 && !evt.rx_desc_fetch &&
        !cmd_wr |=> rx_state == 2'h1)
        else $error("rx did not resume on frame");
    a_partial_mark: assert property (
        evt.rx_overflow && evt.rx_partial_passed && evt.rx_frame_done
        |=> rx_desc_wr.word0[11])
        else $error("partial frame overflow not marked");
    a_opctl_follow: assert property (
        wr_acc && paddr == 16'h1018 |-> ##2
        rx_store_forward == $past(pwdata[25], 2) &&
        rx_flush_on_no_desc == !$past(pwdata[24], 2))
        else $error("rx mode outputs do not follow control");
endmodule : eds_dma_status_monitor

bind eds_dma_status eds_dma_status_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .evt(evt), .rx_frame_status(rx_frame_status), .rx_desc_wr(rx_desc_wr),
    .tx_desc_wr(tx_desc_wr), .rx_state(rx_state), .tx_state(tx_state),
    .rx_store_forward(rx_store_forward),
    .rx_flush_on_no_desc(rx_flush_on_no_desc)
);
`default_nettype wire

// ### dv/eds_dma_engine_model.sv
// far-side model: descriptor fetches and frame events as one-cycle pulses
// assumes the caller enters fire just after a rising edge of pclk
`timescale 1ns/10ps
`default_nettype none

module eds_dma_engine_model (
    input wire logic pclk,
    output eds_pkg::eds_evt_t evt
);
    logic [11:0] ev_reg = 12'h000;
    assign evt = eds_pkg::eds_evt_t'(ev_reg);
    // owned bit is the host handing a descriptor back
    task fire(input logic [11:0] m, input int gap);
        begin
            repeat (gap) @(posedge pclk);
            ev_reg <= m;
            @(posedge pclk);
            ev_reg <= 12'h000;
            @(posedge pclk);
        end
    endtask : fire
endmodule : eds_dma_engine_model
`default_nettype wire

// ### dv/eds_dma_status_test.sv
// self-checking bench for the dma event-flag block over apb
// assumes eds_pkg, the design and the engine model are compiled first
`timescale 1ns/10ps
`default_nettype none

module eds_dma_status_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, q, rx_frame_status = 32'h0;
    logic pready, pslverr, forward_error_frames = 1'b0, irq, tx_start_ok;
    logic tx_fifo_whole_frame = 1'b0;
    logic [8:0] tx_fifo_bytes = 9'h1ff, tx_start_level;
    logic rx_store_forward, rx_flush_on_no_desc, rx_drop_csum_errors;
    eds_pkg::eds_evt_t evt;
    eds_pkg::eds_desc_wr_t rx_desc_wr, tx_desc_wr;
    eds_pkg::eds_proc_t rx_state, tx_state;
    int num_errors = 0, n_compared = 0;
    logic [8:0] lvl [8] = '{9'h040, 9'h080, 9'h0c0, 9'h100,
        9'h028, 9'h020, 9'h018, 9'h010};

    eds_dma_status u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .rx_frame_status(rx_frame_status),
        .forward_error_frames(forward_error_frames),
        .tx_fifo_bytes(tx_fifo_bytes),
        .tx_fifo_whole_frame(tx_fifo_whole_frame),
        .rx_desc_wr(rx_desc_wr), .tx_desc_wr(tx_desc_wr),
        .rx_state(rx_state), .tx_state(tx_state),
        .rx_store_forward(rx_store_forward),
        .rx_flush_on_no_desc(rx_flush_on_no_desc),
        .rx_drop_csum_errors(rx_drop_csum_errors),
        .tx_start_ok(tx_start_ok), .tx_start_level(tx_start_level),
        .irq(irq));
    eds_dma_engine_model u_eng (.pclk(pclk), .evt(evt));

    initial
    begin
        forever #4 pclk = ~pclk;
    end

    task end_of_test;
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 20);
            q = prdata;
            err = pslverr;
            if (n >= 20)
            begin
                num_errors++;
                end_of_test;
            end
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask : xfer

    task rd(input logic [15:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(16'h1018, 32'h0);
        rd(16'h1014, 32'h0);
        rd(16'h1008, 32'h0);
        chk(err, 1'h1);
        xfer(1'b1, 16'h1018, 32'hffffffff);
        rd(16'h1018, 32'h0721c000);
        chk({rx_store_forward, rx_flush_on_no_desc}, 2'h2);
        chk({rx_drop_csum_errors, tx_start_ok}, 2'h0);
        tx_fifo_whole_frame <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(tx_start_ok, 1'h1);
        tx_fifo_whole_frame <= 1'b0;
        xfer(1'b1, 16'h1018, 32'h0);
        forward_error_frames <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(rx_drop_csum_errors, 1'h0);
        forward_error_frames <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(rx_drop_csum_errors, 1'h1);
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, 16'h1018, 32'(i) << 14);
            tx_fifo_bytes <= lvl[i];
            repeat (2) @(posedge pclk);
            chk({tx_start_level, tx_start_ok}, {lvl[i], 1'b0});
            tx_fifo_bytes <= lvl[i] + 9'h001;
            repeat (2) @(posedge pclk);
            chk(tx_start_ok, 1'h1);
        end
        xfer(1'b1, 16'h1000, 32'h1);
        u_eng.fire(12'h003, 0);
        rd(16'h1014, 32'h1);
        xfer(1'b1, 16'h1014, 32'h1);
        u_eng.fire(12'h002, 3);
        rd(16'h1014, 32'h0);
        u_eng.fire(12'h020, 0);
        chk(tx_state, 2'h2);
        xfer(1'b1, 16'h1004, 32'h1);
        chk(tx_state, 2'h1);
        u_eng.fire(12'h008, 1);
        rd(16'h1014, 32'h24);
        xfer(1'b1, 16'h1004, 32'h1);
        u_eng.fire(12'h004, 0);
        chk({tx_state, irq}, 3'h0);
        rd(16'h1014, 32'h2e);
        xfer(1'b1, 16'h101c, 32'hff);
        rd(16'h1014, 32'h802e);
        chk(irq, 1'h1);
        xfer(1'b1, 16'h101c, 32'h1);
        rd(16'h1014, 32'h2e);
        chk(irq, 1'h0);
        xfer(1'b1, 16'h1014, 32'hff);
        rd(16'h1014, 32'h0);
        xfer(1'b1, 16'h101c, 32'hff);
        xfer(1'b1, 16'h1000, 32'h2);
        u_eng.fire(12'hc00, 0);
        u_eng.fire(12'h800, 0);
        chk(rx_state, 2'h2);
        rd(16'h1014, 32'h8080);
        xfer(1'b1, 16'h1014, 32'h80);
        u_eng.fire(12'h200, 0);
        chk(rx_state, 2'h1);
        u_eng.fire(12'h800, 0);
        rd(16'h1014, 32'h0);
        xfer(1'b1, 16'h1004, 32'h2);
        chk(rx_state, 2'h1);
        rx_frame_status <= 32'h00000123;
        u_eng.fire(12'h1c0, 0);
        chk(rx_state, 2'h1);
        rd(16'h1014, 32'h8050);
        xfer(1'b1, 16'h1000, 32'h1);
        rd(16'h1000, 32'h11);
        xfer(1'b1, 16'h1014, 32'hff);
        xfer(1'b1, 16'h1000, 32'hc);
        rd(16'h1000, 32'h0);
        rd(16'h1014, 32'h8002);
        chk(irq, 1'h1);
        end_of_test;
    end
endmodule : eds_dma_status_test
`default_nettype wire
